// >>> shared/rsc_pkg.sv
`default_nettype none
package rsc_pkg;

    // Clock and time base
    localparam int unsigned CLK_FREQ_HZ      = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_FREQ_HZ;

    // Power-on release delay, printed in microseconds
    localparam int unsigned T_POR_US         = 300;
    localparam int unsigned POR_DELAY_CYCLES = T_POR_US * (CLK_FREQ_HZ / 1_000_000);

    // Least hold time of any reset, rounded up to whole cycles
    localparam int unsigned T_HOLD_NS        = 160;
    localparam int unsigned HOLD_CYCLES      =
        (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Time the pin is ignored after the controller stops driving it
    localparam int unsigned T_PIN_GUARD_NS   = 120;
    localparam int unsigned PIN_GUARD_CYCLES =
        (T_PIN_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register indices; byte address is four times the index
    localparam logic [11:0] CAUSE_REG_INDEX   = 12'h0ef;
    localparam logic [11:0] MONITOR_REG_INDEX = 12'h0ff;
    localparam logic [31:0] CAUSE_REG_ADDR    = {18'h00000, CAUSE_REG_INDEX, 2'h0};
    localparam logic [31:0] MONITOR_REG_ADDR  = {18'h00000, MONITOR_REG_INDEX, 2'h0};

    // Write-side bit positions of the cause register
    localparam int unsigned WR_CMP_ENABLE_BIT = 5;
    localparam int unsigned WR_SW_FORCE_BIT   = 4;
    localparam int unsigned WR_MCD_ENABLE_BIT = 2;
    localparam int unsigned WR_MON_SELECT_BIT = 1;

    // Bit positions of the supply monitor control register
    localparam int unsigned MON_ENABLE_BIT    = 7;
    localparam int unsigned MON_STATUS_BIT    = 6;

    // Reset values
    localparam logic [7:0]  CAUSE_POR_VALUE   = 8'h02;
    localparam logic        MON_ENABLE_RESET  = 1'b1;
    localparam logic        MON_SELECT_RESET  = 1'b1;
    localparam logic        MCD_ENABLE_RESET  = 1'b0;
    localparam logic        CMP_ENABLE_RESET  = 1'b0;
    localparam logic [4:0]  SOURCES_IDLE      = 5'h10;

    // State forced onto the core for reset exit
    localparam logic [15:0] PC_START          = 16'h0000;
    localparam logic [7:0]  PORT_LATCH_RESET  = 8'hff;

    // Bus encodings
    localparam logic [1:0]  HTRANS_NONSEQ     = 2'h2;
    localparam logic        HRESP_OKAY        = 1'h0;

    // Cause flags in their read-back bit order
    typedef struct packed {
        logic reserved;
        logic flash;
        logic comparator;
        logic software;
        logic watchdog;
        logic missing_clock;
        logic power_on;
        logic pin;
    } rsc_causes_t;

    // Asynchronous reset sources, pin is active low
    typedef struct packed {
        logic pin_n;
        logic supply_low;
        logic comparator_low;
        logic clock_stall;
        logic watchdog_expire;
    } rsc_sources_t;

    // Defaults presented to the core and ports during reset
    typedef struct packed {
        logic [15:0] pc_start;
        logic [7:0]  port_latch;
        logic        open_drain;
        logic        low_drive;
        logic        weak_pullup;
        logic        watchdog_enable;
        logic        internal_osc;
    } rsc_exit_t;

endpackage
`default_nettype wire

// >>> logic/rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
    parameter int unsigned        WIDTH     = 1,
    parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;

    // Two-stage synchroniser, first stage feeds only the second
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            meta_q <= RESET_VAL;
            q      <= RESET_VAL;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule // rsc_sync
`default_nettype wire

// >>> logic/rsc_controller.sv
// Behaviour
// - reset halts core, loads registers, quiets interrupts
// - data memory kept; only stack pointer reloads
// - port latches all ones, open-drain, pullups on
// - power-on and supply resets drive pin low
// - exit: PC zero, watchdog on, internal oscillator
// - power-on flag set; other resets clear it
// - power-on enables and selects supply monitor
// - monitored low supply drives pin, holds core
// - supply reset skips power-on delay, flags power-on
// - power-on sets monitor enable and select; bus writes to the monitor and cause registers also change them
// - flash erase/write ignored while monitor disabled
// - low pin resets; pin flag set afterwards
// - missing clock detector timeout causes reset
// - missing clock flag reads cause; write enables
// - internal resets leave the reset pin alone
// - comparator enable bit; reset while input low
// - watchdog expiry resets and sets its flag
// - flash access faults reset and set flag
// - software force bit resets and reads back
// - cause reads and enable writes are separate
`timescale 1ns/1ps
`default_nettype none
module rsc_controller #(
    parameter int unsigned POR_DELAY = rsc_pkg::POR_DELAY_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 reset,
    // AHB-Lite slave
    input  wire logic                 hsel,
    input  wire logic [31:0]          haddr,
    input  wire logic [1:0]           htrans,
    input  wire logic                 hwrite,
    input  wire logic [2:0]           hsize,
    input  wire logic [31:0]          hwdata,
    input  wire logic                 hready,
    output logic                      hreadyout,
    output logic                      hresp,
    output logic      [31:0]          hrdata,
    // Asynchronous reset sources
    input  wire rsc_pkg::rsc_sources_t sources_async,
    // Same-clock fault and flash requests
    input  wire logic                 flash_fault,
    input  wire logic                 flash_write_req,
    input  wire logic                 flash_erase_req,
    output logic                      flash_write_ok,
    output logic                      flash_erase_ok,
    // Reset pin, open drain
    output logic                      reset_pin_out,
    output logic                      reset_pin_oe,
    // Core side
    output logic                      core_reset,
    output rsc_pkg::rsc_exit_t        exit_cfg,
    output rsc_pkg::rsc_causes_t      causes
);
    import rsc_pkg::*;

    localparam int unsigned PW = $clog2(POR_DELAY + 1);
    localparam int unsigned HW = $clog2(HOLD_CYCLES + 1);
    localparam int unsigned GW = $clog2(PIN_GUARD_CYCLES + 1);

    typedef enum logic [1:0] {
        ST_POR_DELAY,
        ST_HOLD,
        ST_RUN
    } rsc_state_t;

    rsc_state_t   state_q;
    rsc_sources_t src;
    rsc_causes_t  cause_q;
    rsc_causes_t  entry_cause;
    logic [PW-1:0] por_cnt_q;
    logic [HW-1:0] hold_cnt_q;
    logic [GW-1:0] guard_cnt_q;
    logic          pin_drive_q;
    logic          mon_enable_q;
    logic          mon_select_q;
    logic          mcd_enable_q;
    logic          cmp_enable_q;
    logic          sw_req_q;
    logic          wr_pend_q;
    logic [31:0]   wr_addr_q;
    logic [31:0]   hrdata_q;
    logic          core_reset_q;
    rsc_exit_t     exit_cfg_q;
    logic          addr_phase;
    logic [31:0]   read_word;
    logic          supply_trip;
    logic          pin_trip;
    logic          mcd_trip;
    logic          cmp_trip;
    logic          wdt_trip;
    logic          flash_trip;
    logic          any_trip;
    logic          level_active;
    logic          guard_done;

    // Pins and foreign-clock sources enter through two flip-flops
    rsc_sync #(
        .WIDTH     (5),
        .RESET_VAL (SOURCES_IDLE)
    ) rsc_sync_i (
        .clk   (clk),
        .reset (reset),
        .d     (sources_async),
        .q     (src)
    );

    // Trip conditions from each source
    assign guard_done  = (guard_cnt_q == '0);
    assign supply_trip = mon_enable_q & mon_select_q & src.supply_low;
    assign pin_trip    = ~src.pin_n & ~pin_drive_q & guard_done;
    assign mcd_trip    = mcd_enable_q & src.clock_stall;
    assign cmp_trip    = cmp_enable_q & src.comparator_low;
    assign wdt_trip    = src.watchdog_expire;
    assign flash_trip  = flash_fault;
    assign any_trip    = supply_trip | pin_trip | mcd_trip | cmp_trip
                       | wdt_trip | flash_trip | sw_req_q;

    // Sources that keep the core in reset while they last
    assign level_active = supply_trip | mcd_trip | cmp_trip
                        | (~src.pin_n & ~pin_drive_q);

    // Cause word taken at reset entry
    always_comb begin
        entry_cause = '0;
        if (supply_trip) begin
            entry_cause.power_on = 1'b1;
        end else begin
            entry_cause.pin           = pin_trip;
            entry_cause.missing_clock = mcd_trip;
            entry_cause.comparator    = cmp_trip;
            entry_cause.watchdog      = wdt_trip;
            entry_cause.flash         = flash_trip;
            entry_cause.software      = sw_req_q;
            entry_cause.power_on      = 1'b0;
        end
    end

    // Sequencer state
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            state_q <= ST_POR_DELAY;
        end else begin
            unique case (state_q)
                ST_POR_DELAY: begin
                    if (por_cnt_q == '0 && !src.supply_low) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_HOLD: begin
                    if (hold_cnt_q == '0 && !level_active) begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (any_trip) begin
                        state_q <= ST_HOLD;
                    end
                end
                default: begin
                    state_q <= ST_HOLD;
                end
            endcase
        end
    end

    // Power-on release delay, only after a true power-on
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            por_cnt_q <= PW'(POR_DELAY);
        end else if (state_q == ST_POR_DELAY && por_cnt_q != '0) begin
            por_cnt_q <= por_cnt_q - PW'(1);
        end
    end

    // Least hold time for every other reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            hold_cnt_q <= '0;
        end else if (state_q == ST_RUN) begin
            hold_cnt_q <= HW'(HOLD_CYCLES);
        end else if (hold_cnt_q != '0) begin
            hold_cnt_q <= hold_cnt_q - HW'(1);
        end
    end

    // Cause flags captured at entry and frozen through reset
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cause_q <= rsc_causes_t'(CAUSE_POR_VALUE);
        end else if (state_q == ST_RUN && any_trip) begin
            cause_q <= entry_cause;
        end
    end

    // Reset pin driven low only for power-on and supply resets
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_drive_q <= 1'b1;
        end else if (state_q == ST_RUN) begin
            pin_drive_q <= any_trip & supply_trip;
        end else if (state_q == ST_POR_DELAY) begin
            if (por_cnt_q == '0 && !src.supply_low) begin
                pin_drive_q <= 1'b0;
            end
        end else if (state_q == ST_HOLD) begin
            if (hold_cnt_q == '0 && !level_active) begin
                pin_drive_q <= 1'b0;
            end
        end
    end

    // Pin ignored briefly after release while it floats back up
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            guard_cnt_q <= GW'(PIN_GUARD_CYCLES);
        end else if (pin_drive_q) begin
            guard_cnt_q <= GW'(PIN_GUARD_CYCLES);
        end else if (guard_cnt_q != '0) begin
            guard_cnt_q <= guard_cnt_q - GW'(1);
        end
    end

    // Core reset level, high while not running or on a trip
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            core_reset_q <= 1'b1;
        end else begin
            core_reset_q <= (state_q != ST_RUN) || any_trip;
        end
    end

    // Defaults held in and out of reset; data memory has no reset path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            exit_cfg_q.pc_start        <= PC_START;
            exit_cfg_q.port_latch      <= PORT_LATCH_RESET;
            exit_cfg_q.open_drain      <= 1'b1;
            exit_cfg_q.low_drive       <= 1'b1;
            exit_cfg_q.weak_pullup     <= 1'b1;
            exit_cfg_q.watchdog_enable <= 1'b1;
            exit_cfg_q.internal_osc    <= 1'b1;
        end else begin
            exit_cfg_q.pc_start        <= PC_START;
            exit_cfg_q.port_latch      <= PORT_LATCH_RESET;
            exit_cfg_q.open_drain      <= 1'b1;
            exit_cfg_q.low_drive       <= 1'b1;
            exit_cfg_q.weak_pullup     <= 1'b1;
            exit_cfg_q.watchdog_enable <= 1'b1;
            exit_cfg_q.internal_osc    <= 1'b1;
        end
    end

    // Bus address phase
    assign addr_phase = hsel & hready & (htrans == HTRANS_NONSEQ);

    // Read mux; enables written through the cause register are write-only and never shown
    always_comb begin
        read_word = '0;
        if (haddr == CAUSE_REG_ADDR) begin
            read_word = {24'h000000, cause_q};
            read_word[7] = 1'b0;
        end else if (haddr == MONITOR_REG_ADDR) begin
            read_word[MON_ENABLE_BIT] = mon_enable_q;
            read_word[MON_STATUS_BIT] = ~src.supply_low;
        end
    end

    // Write pending and read data capture
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            hrdata_q  <= '0;
        end else begin
            wr_pend_q <= addr_phase & hwrite;
            if (addr_phase) begin
                wr_addr_q <= haddr;
                hrdata_q  <= hwrite ? 32'h00000000 : read_word;
            end
        end
    end

    // Supply monitor enable and select set at power-on and by bus writes
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mon_enable_q <= MON_ENABLE_RESET;
            mon_select_q <= MON_SELECT_RESET;
        end else if (wr_pend_q) begin
            if (wr_addr_q == MONITOR_REG_ADDR) begin
                mon_enable_q <= hwdata[MON_ENABLE_BIT];
            end
            if (wr_addr_q == CAUSE_REG_ADDR) begin
                mon_select_q <= hwdata[WR_MON_SELECT_BIT];
            end
        end
    end

    // Source enables written through the cause register
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mcd_enable_q <= MCD_ENABLE_RESET;
            cmp_enable_q <= CMP_ENABLE_RESET;
        end else if (wr_pend_q && wr_addr_q == CAUSE_REG_ADDR) begin
            mcd_enable_q <= hwdata[WR_MCD_ENABLE_BIT];
            cmp_enable_q <= hwdata[WR_CMP_ENABLE_BIT];
        end
    end

    // Software force, one-cycle request
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sw_req_q <= 1'b0;
        end else begin
            sw_req_q <= wr_pend_q && wr_addr_q == CAUSE_REG_ADDR
                        && hwdata[WR_SW_FORCE_BIT];
        end
    end

    // Flash erase and write gated by the monitor enable
    assign flash_write_ok = flash_write_req & mon_enable_q;
    assign flash_erase_ok = flash_erase_req & mon_enable_q;

    // Bus outputs, slave never stalls
    assign hreadyout     = 1'b1;
    assign hresp         = HRESP_OKAY;
    assign hrdata        = hrdata_q;

    // Pin only ever pulled low; core reset and exit state
    assign reset_pin_out = 1'b0;
    assign reset_pin_oe  = pin_drive_q;
    assign core_reset    = core_reset_q;
    assign exit_cfg      = exit_cfg_q;
    assign causes        = cause_q;

endmodule // rsc_controller
`default_nettype wire

// >>> verif/rsc_controller_sva.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_controller_sva
    import rsc_pkg::*;
#(
    parameter int unsigned POR_DELAY = POR_DELAY_CYCLES
) (
    input wire logic                 clk,
    input wire logic                 reset,
    input wire logic                 hreadyout,
    input wire logic                 hresp,
    input wire logic                 flash_fault,
    input wire logic                 flash_write_req,
    input wire logic                 flash_erase_req,
    input wire logic                 flash_write_ok,
    input wire logic                 flash_erase_ok,
    input wire logic                 reset_pin_out,
    input wire logic                 reset_pin_oe,
    input wire logic                 core_reset,
    input wire rsc_pkg::rsc_exit_t   exit_cfg,
    input wire rsc_pkg::rsc_causes_t causes
);
    localparam rsc_exit_t EXIT_ON = {PC_START, PORT_LATCH_RESET, 5'h1f};

    // One clock domain, async reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Bus, pin, flash, hold, cause and exit checks
    AST_BUS_OKAY: assert property (hreadyout && hresp == HRESP_OKAY)
        else $error("bus slave not ready or not okay");
    AST_PIN_OPEN_DRAIN: assert property (reset_pin_oe |-> !reset_pin_out)
        else $error("reset pin driven high");
    AST_FLASH_GATE: assert property ((flash_write_ok |-> flash_write_req)
        and (flash_erase_ok |-> flash_erase_req)) else $error("flash grant without request");
    AST_FLASH_TRIP: assert property (flash_fault && !core_reset |-> ##[1:2] core_reset)
        else $error("flash fault did not reset core");
    AST_FLASH_FLAG: assert property ($rose(core_reset) && $past(flash_fault) |->
        causes.flash && !causes.power_on) else $error("flash cause flag wrong");
    AST_HOLD: assert property ($rose(core_reset) |-> core_reset [*4])
        else $error("reset shorter than hold time");
    AST_CAUSE_HELD: assert property (core_reset && $past(core_reset) |-> $stable(causes))
        else $error("cause flags moved during reset");
    AST_INTERNAL_NO_PIN: assert property (core_reset && !causes.power_on |-> !reset_pin_oe)
        else $error("internal reset drove pin");
    AST_POWER_PIN: assert property (core_reset && causes.power_on |->
        reset_pin_oe || $fell(reset_pin_oe)) else $error("pin not driven in supply reset");
    AST_RELEASE_ORDER: assert property ($fell(reset_pin_oe) |-> core_reset ##1 !core_reset)
        else $error("pin and core release out of order");
    AST_EXIT_RUN: assert property (!core_reset [*3] |-> exit_cfg == EXIT_ON)
        else $error("exit state wrong while running");

    // Main scenarios reached
    COV_TRIP: cover property ($rose(core_reset));
    COV_FLASH_OK: cover property (flash_write_ok && flash_erase_ok);
    COV_PIN_DRIVE: cover property ($fell(reset_pin_oe));
endmodule // rsc_controller_sva

bind rsc_controller rsc_controller_sva #(.POR_DELAY(POR_DELAY)) rsc_controller_sva_i (
    .clk(clk), .reset(reset), .hreadyout(hreadyout), .hresp(hresp),
    .flash_fault(flash_fault), .flash_write_req(flash_write_req),
    .flash_erase_req(flash_erase_req), .flash_write_ok(flash_write_ok),
    .flash_erase_ok(flash_erase_ok), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .core_reset(core_reset), .exit_cfg(exit_cfg),
    .causes(causes)
);
`default_nettype wire

// >>> verif/rsc_ext_model.sv
`timescale 1ns/1ps
`default_nettype none
module rsc_ext_model
    import rsc_pkg::*;
(
    input  wire logic               reset_pin_oe,
    input  wire logic               reset_pin_out,
    input  wire logic               ext_pin_low,
    input  wire logic               supply_dip,
    input  wire logic               cmp_below,
    input  wire logic               clk_gap,
    input  wire logic               wdog_miss,
    output var rsc_pkg::rsc_sources_t sources_async
);
    logic pin_level;

    // Open-drain reset line with pull-up, any party pulls it low
    assign pin_level = !((reset_pin_oe && !reset_pin_out) || ext_pin_low);

    // Supply, comparator, detector and watchdog seen as plain levels
    assign sources_async = {pin_level, supply_dip, cmp_below, clk_gap, wdog_miss};
endmodule // rsc_ext_model
`default_nettype wire

// >>> verif/test_reset_source_controller.sv
`timescale 1ns/1ps
`default_nettype none
module test_reset_source_controller;
    import rsc_pkg::*;
    localparam int PORD = 20;
    logic         clk = 1'b0;
    logic         reset = 1'b1;
    logic         hsel = 1'b0;
    logic [31:0]  haddr = '0;
    logic [1:0]   htrans = 2'h0;
    logic         hwrite = 1'b0;
    logic [2:0]   hsize = 3'h2;
    logic [31:0]  hwdata = '0;
    logic         ff = 1'b0;
    logic         fw = 1'b0;
    logic         fe = 1'b0;
    logic [4:0]   drv = '0;
    logic         hreadyout, hresp, fw_ok, fe_ok, pin_out, pin_oe, core_reset;
    logic [31:0]  hrdata, rdv;
    rsc_sources_t src;
    rsc_exit_t    exit_cfg;
    rsc_causes_t  causes;
    int           bad_count = 0;
    int           n_tests = 0;
    int           n;
    // Enable write, source index, expected flags; comparator input is driven low only after its enable is written
    logic [7:0]   en_t[6] = '{8'h04, 8'h20, 8'h00, 8'h00, 8'h00, 8'h10};
    int           src_t[6] = '{1, 2, 0, 4, 5, 6};
    logic [7:0]   exp_t[6] = '{8'h04, 8'h20, 8'h08, 8'h01, 8'h40, 8'h10};

    // Clock
    always #20 clk = ~clk;

    rsc_controller #(.POR_DELAY(PORD)) rsc_controller_i (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sources_async(src),
        .flash_fault(ff), .flash_write_req(fw), .flash_erase_req(fe),
        .flash_write_ok(fw_ok), .flash_erase_ok(fe_ok), .reset_pin_out(pin_out),
        .reset_pin_oe(pin_oe), .core_reset(core_reset), .exit_cfg(exit_cfg),
        .causes(causes));

    rsc_ext_model rsc_ext_model_i (
        .reset_pin_oe(pin_oe), .reset_pin_out(pin_out), .ext_pin_low(drv[4]),
        .supply_dip(drv[3]), .cmp_below(drv[2]), .clk_gap(drv[1]),
        .wdog_miss(drv[0]), .sources_async(src));

    task automatic check32(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask

    task automatic check1(input logic got, input logic exp, input string m);
        check32({31'h0, got}, {31'h0, exp}, m);
    endtask

    // Single AHB-Lite transfer, read data left in rdv
    // Waits end only when ready comes; the bench watchdog catches a stuck bus
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= w;
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask

    task automatic rchk(input logic [31:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check32(rdv, e, "register read");
    endtask

    task automatic wait_core(input logic v);
        int k;
        k = 0;
        do @(posedge clk); while (core_reset !== v && ++k < 200);
        check1(core_reset, v, "core reset level");
    endtask

    // Raise one source, wait for reset in and out, read flags
    task automatic trip(input logic [7:0] en, input int s, input logic [7:0] e);
        bus(1'b1, CAUSE_REG_ADDR, {24'h0, en});
        @(posedge clk);
        drv <= (s < 5) ? (5'h01 << s) : 5'h00;
        ff <= (s == 5);
        wait_core(1'b1);
        check1(pin_oe, 1'b0, "pin driven by internal reset");
        drv <= '0;
        ff <= 1'b0;
        wait_core(1'b0);
        rchk(CAUSE_REG_ADDR, {24'h0, e});
        check32({24'h0, causes}, {24'h0, e}, "cause output");
    endtask

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge clk);
        check1(core_reset, 1'b1, "core held in reset");
        check1(pin_oe, 1'b1, "pin driven at power-on");
        check32({3'h0, exit_cfg}, {3'h0, PC_START, PORT_LATCH_RESET, 5'h1f}, "in reset");
        reset <= 1'b0;
        wait_core(1'b0);
        repeat (2) @(posedge clk);
        check32({3'h0, exit_cfg}, {3'h0, PC_START, PORT_LATCH_RESET, 5'h1f}, "exit");
        check1(pin_oe, 1'b0, "pin released");
        rchk(CAUSE_REG_ADDR, 32'h02);
        rchk(MONITOR_REG_ADDR, 32'hc0);
        rchk(32'h0000_0010, 32'h0);
        bus(1'b1, CAUSE_REG_ADDR, 32'h24);
        rchk(CAUSE_REG_ADDR, 32'h02);
        $display("test power_on done");
        fw <= 1'b1;
        fe <= 1'b1;
        @(posedge clk);
        check1(fw_ok & fe_ok, 1'b1, "flash allowed");
        bus(1'b1, MONITOR_REG_ADDR, 32'h0);
        @(posedge clk);
        check1(fw_ok | fe_ok, 1'b0, "flash ignored");
        fw <= 1'b0;
        fe <= 1'b0;
        $display("test flash gating done");
        for (int i = 0; i < 6; i++) begin
            trip(en_t[i], src_t[i], exp_t[i]);
        end
        rchk(MONITOR_REG_ADDR, 32'h40);
        bus(1'b1, CAUSE_REG_ADDR, 32'h0);
        drv[1] <= 1'b1;
        repeat (10) @(posedge clk);
        check1(core_reset, 1'b0, "disabled detector ignored");
        drv <= '0;
        $display("test source table done");
        bus(1'b1, MONITOR_REG_ADDR, 32'h80);
        bus(1'b1, CAUSE_REG_ADDR, 32'h02);
        drv[3] <= 1'b1;
        wait_core(1'b1);
        check1(pin_oe, 1'b1, "pin driven in supply reset");
        repeat (8) @(posedge clk);
        drv <= '0;
        n = 0;
        do @(posedge clk); while (core_reset !== 1'b0 && ++n < 200);
        check1(n < PORD, 1'b1, "supply release without delay");
        rchk(CAUSE_REG_ADDR, 32'h02);
        $display("test supply done");
        bus(1'b1, MONITOR_REG_ADDR, 32'h0);
        bus(1'b1, CAUSE_REG_ADDR, 32'h0);
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        wait_core(1'b0);
        rchk(MONITOR_REG_ADDR, 32'hc0);
        rchk(CAUSE_REG_ADDR, 32'h02);
        drv[3] <= 1'b1;
        wait_core(1'b1);
        check1(pin_oe, 1'b1, "monitor reselected at power-on");
        drv <= '0;
        wait_core(1'b0);
        $display("test second power_on done");
        wrap_up();
    end

    // Watchdog against hangs
    initial begin
        #(40 * 20000);
        bad_count++;
        $display("CHECK FAILED at %0t: run timed out", $time);
        wrap_up();
    end
endmodule // test_reset_source_controller
`default_nettype wire
